// ===== core/otpcs_pkg.sv
// Package with addresses, field positions, codes and states of the OTP status/FIFO block.
package otpcs_pkg;
  // ==========================================================================
  // Register byte addresses.
  localparam logic [31:0] ADDR_CTRL     = 32'h4000_8000;
  localparam logic [31:0] ADDR_STAT     = 32'h4000_8008;
  localparam logic [31:0] ADDR_DMA      = 32'h4000_800c;
  localparam logic [31:0] ADDR_CELL     = 32'h4000_8010;
  localparam logic [31:0] ADDR_COUNT    = 32'h4000_8014;
  localparam logic [31:0] ADDR_PORT     = 32'h4000_8018;
  localparam logic [31:0] ADDR_LAST     = 32'h4000_801c;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h4000_8020;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000_8024;
  // ==========================================================================
  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DMA_BIT  = 4;
  localparam int CTRL_PSEL_BIT = 5;
  localparam int CTRL_GO_BIT   = 8;
  // Status register fields.
  localparam int STAT_NWORDS_LSB = 16;
  localparam int STAT_PERR_U     = 13;
  localparam int STAT_PERR_L     = 12;
  localparam int STAT_FWORDS_LSB = 8;
  localparam int STAT_ARDY       = 4;
  localparam int STAT_TERR       = 3;
  localparam int STAT_TRDY       = 2;
  localparam int STAT_PERR       = 1;
  localparam int STAT_PRDY       = 0;
  // Interrupt status and mask bits.
  localparam int IRQ_AUTO_DONE = 0;
  localparam int IRQ_TEST_DONE = 1;
  localparam int IRQ_MAN_DONE  = 2;
  localparam int IRQ_PROG_FAIL = 3;
  // ==========================================================================
  // FIFO geometry and bus answers.
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [3:0]  FIFO_FULL   = 4'h8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [13:0] ONE14       = 14'h1;
  // Operating modes, also the operation code sent to the macrocell.
  localparam logic [2:0] MODE_STANDBY    = 3'h0;
  localparam logic [2:0] MODE_AUTO_READ  = 3'h1;
  localparam logic [2:0] MODE_AUTO_PROG  = 3'h2;
  localparam logic [2:0] MODE_MAN_PROG   = 3'h3;
  localparam logic [2:0] MODE_BLANK_TEST = 3'h4;
  localparam logic [2:0] MODE_DEC_TEST   = 3'h5;
  localparam logic [2:0] MODE_TWRITE     = 3'h6;
  // Sequencer states.
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_RUN  = 3'b010,
    S_CELL = 3'b100
  } otpcs_state_t;
endpackage : otpcs_pkg

// ===== core/otpcs_ctrl.sv
// OTP controller status, address, word-count and FIFO port block with AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module otpcs_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             irq,
  output logic             cellReq,
  output logic [2:0]       cellOp,
  output logic [12:0]      cellAddr,
  output logic [31:0]      cellWdata,
  input  wire logic        cellAck,
  input  wire logic [31:0] cellRdata,
  input  wire logic        cellFailUpper,
  input  wire logic        cellFailLower,
  output logic             dmaReq,
  output logic             dmaWrite,
  output logic [31:0]      dmaAddr,
  output logic [31:0]      dmaWdata,
  input  wire logic        dmaAck,
  input  wire logic [31:0] dmaRdata
);
  // ==========================================================================
  // State record.
  typedef struct packed {
    otpcs_pkg::otpcs_state_t st;
    logic [2:0]              modeSel;
    logic                    dmaEn;
    logic                    portSel;
    logic [2:0]              opMode;
    logic [29:0]             dmaWordAddr;
    logic [12:0]             cellAddr;
    logic [12:0]             wordCount;
    logic [13:0]             remaining;
    logic [13:0]             dmaLeft;
    logic [31:0]             portWord;
    logic [31:0]             lastRead;
    logic [7:0][31:0]        mem;
    logic [2:0]              rdPtr;
    logic [2:0]              wrPtr;
    logic [3:0]              count;
    logic                    cellReq;
    logic [31:0]             cellWdata;
    logic                    dmaReq;
    logic                    dmaWrite;
    logic [31:0]             dmaWdata;
    logic                    testFail;
    logic                    progFail;
    logic                    failU;
    logic                    failL;
    logic [3:0]              irqStat;
    logic [3:0]              irqMask;
    logic                    bValid;
    logic [1:0]              bResp;
    logic                    rValid;
    logic [31:0]             rData;
    logic [1:0]              rResp;
  } otpcs_regs_t;

  otpcs_regs_t q;
  otpcs_regs_t d;

  // Byte-lane merge of a write into an existing word.
  function automatic logic [31:0] otpcs_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : otpcs_merge

  // Address decode shared by the read and write paths.
  function automatic logic otpcs_mapped(input logic [31:0] a);
    return a == otpcs_pkg::ADDR_CTRL || a == otpcs_pkg::ADDR_STAT || a == otpcs_pkg::ADDR_DMA
        || a == otpcs_pkg::ADDR_CELL || a == otpcs_pkg::ADDR_COUNT || a == otpcs_pkg::ADDR_PORT
        || a == otpcs_pkg::ADDR_LAST || a == otpcs_pkg::ADDR_IRQ_STAT
        || a == otpcs_pkg::ADDR_IRQ_MASK;
  endfunction : otpcs_mapped

  // ==========================================================================
  // Status view and handshakes.
  logic        wrEn;
  logic        rdEn;
  logic        autoOp;
  logic        autoReady;
  logic        testReady;
  logic        progIdle;
  logic [31:0] head;
  logic [31:0] statWord;

  // Ready bits fall while the matching sequence runs.
  always_comb begin
    autoOp    = q.opMode == otpcs_pkg::MODE_AUTO_READ || q.opMode == otpcs_pkg::MODE_AUTO_PROG;
    autoReady = !(q.st != otpcs_pkg::S_IDLE && autoOp);
    testReady = !(q.st == otpcs_pkg::S_CELL
                  && q.opMode >= otpcs_pkg::MODE_BLANK_TEST);
    progIdle  = !(q.st == otpcs_pkg::S_CELL && (q.opMode == otpcs_pkg::MODE_AUTO_PROG
                  || q.opMode == otpcs_pkg::MODE_MAN_PROG));
    head      = q.mem[q.rdPtr];
    statWord  = '0;
    statWord[otpcs_pkg::STAT_NWORDS_LSB +: 13] = q.remaining[12:0];
    statWord[otpcs_pkg::STAT_PERR_U]           = q.failU;
    statWord[otpcs_pkg::STAT_PERR_L]           = q.failL;
    statWord[otpcs_pkg::STAT_FWORDS_LSB +: 4]  = q.count;
    statWord[otpcs_pkg::STAT_ARDY]             = autoReady;
    statWord[otpcs_pkg::STAT_TERR]             = q.testFail;
    statWord[otpcs_pkg::STAT_TRDY]             = testReady;
    statWord[otpcs_pkg::STAT_PERR]             = q.progFail;
    statWord[otpcs_pkg::STAT_PRDY]             = progIdle;
  end

  // A write is taken when address and data are both offered and no write response is pending.
  assign wrEn    = awvalid && wvalid && !q.bValid;
  assign awready = wrEn;
  assign wready  = wrEn;
  assign rdEn    = arvalid && !q.rValid;
  assign arready = rdEn;

  // ==========================================================================
  // Next-state logic.
  always_comb begin
    logic [31:0] mw;
    logic        go;
    logic        swPush;
    logic        swPop;
    logic        hwPush;
    logic        hwPop;
    logic [31:0] pushData;
    logic [3:0]  irqSet;
    logic [31:0] mt;
    mw       = otpcs_merge(q.portWord, wdata, wstrb);
    go       = 1'b0;
    swPush   = 1'b0;
    swPop    = 1'b0;
    hwPush   = 1'b0;
    hwPop    = 1'b0;
    pushData = '0;
    irqSet   = '0;
    mt       = '0;
    d        = q;

    // Bus answers retire on their ready.
    if (q.bValid && bready) begin
      d.bValid = 1'b0;
    end
    if (q.rValid && rready) begin
      d.rValid = 1'b0;
    end

    // Register writes.
    if (wrEn) begin
      d.bValid = 1'b1;
      d.bResp  = otpcs_mapped(awaddr) ? otpcs_pkg::RESP_OKAY : otpcs_pkg::RESP_SLVERR;
      case (awaddr)
        otpcs_pkg::ADDR_CTRL: begin
          if (wstrb[0]) begin
            d.modeSel = wdata[otpcs_pkg::CTRL_MODE_LSB +: 3];
            d.dmaEn   = wdata[otpcs_pkg::CTRL_DMA_BIT];
            d.portSel = wdata[otpcs_pkg::CTRL_PSEL_BIT];
          end
          go = wstrb[1] && wdata[otpcs_pkg::CTRL_GO_BIT];
        end
        otpcs_pkg::ADDR_DMA: begin
          mt            = otpcs_merge({q.dmaWordAddr, 2'b00}, wdata, wstrb);
          d.dmaWordAddr = mt[31:2];
        end
        otpcs_pkg::ADDR_CELL: begin
          mt         = otpcs_merge({19'h0, q.cellAddr}, wdata, wstrb);
          d.cellAddr = mt[12:0];
        end
        otpcs_pkg::ADDR_COUNT: begin
          mt          = otpcs_merge({19'h0, q.wordCount}, wdata, wstrb);
          d.wordCount = mt[12:0];
        end
        otpcs_pkg::ADDR_PORT: begin
          d.portWord = mw;
          swPush     = q.modeSel == otpcs_pkg::MODE_AUTO_PROG && !q.dmaEn
                       && q.count != otpcs_pkg::FIFO_FULL;
        end
        otpcs_pkg::ADDR_IRQ_STAT: begin
          d.irqStat = q.irqStat & ~wdata[3:0];
        end
        otpcs_pkg::ADDR_IRQ_MASK: begin
          d.irqMask = wdata[3:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads; a port read in automatic read mode without DMA pops the FIFO.
    if (rdEn) begin
      d.rValid = 1'b1;
      d.rResp  = otpcs_mapped(araddr) ? otpcs_pkg::RESP_OKAY : otpcs_pkg::RESP_SLVERR;
      swPop    = araddr == otpcs_pkg::ADDR_PORT && q.modeSel == otpcs_pkg::MODE_AUTO_READ
                 && !q.dmaEn && q.count != 4'h0;
      case (araddr)
        otpcs_pkg::ADDR_CTRL:     d.rData = {26'h0, q.portSel, q.dmaEn, 1'b0, q.modeSel};
        otpcs_pkg::ADDR_STAT:     d.rData = statWord;
        otpcs_pkg::ADDR_DMA:      d.rData = {q.dmaWordAddr, 2'b00};
        otpcs_pkg::ADDR_CELL:     d.rData = {19'h0, q.cellAddr};
        otpcs_pkg::ADDR_COUNT:    d.rData = {19'h0, q.wordCount};
        otpcs_pkg::ADDR_PORT:     d.rData = swPop ? head : q.portWord;
        otpcs_pkg::ADDR_LAST:     d.rData = q.lastRead;
        otpcs_pkg::ADDR_IRQ_STAT: d.rData = {28'h0, q.irqStat};
        otpcs_pkg::ADDR_IRQ_MASK: d.rData = {28'h0, q.irqMask};
        default:                  d.rData = '0;
      endcase
      if (swPop) begin
        d.lastRead = head;
      end
    end

    // Sequencer for automatic, manual and test operations.
    case (q.st)
      otpcs_pkg::S_IDLE: begin
        if (go) begin
          d.opMode    = d.modeSel;
          d.remaining = {1'b0, q.wordCount} + otpcs_pkg::ONE14;
          d.dmaLeft   = {1'b0, q.wordCount} + otpcs_pkg::ONE14;
          d.testFail  = 1'b0;
          d.progFail  = 1'b0;
          d.failU     = 1'b0;
          d.failL     = 1'b0;
          case (d.modeSel)
            otpcs_pkg::MODE_AUTO_READ, otpcs_pkg::MODE_AUTO_PROG: d.st = otpcs_pkg::S_RUN;
            otpcs_pkg::MODE_MAN_PROG: begin
              d.st        = otpcs_pkg::S_CELL;
              d.cellReq   = 1'b1;
              d.cellWdata = q.portWord;
            end
            otpcs_pkg::MODE_BLANK_TEST, otpcs_pkg::MODE_DEC_TEST, otpcs_pkg::MODE_TWRITE: begin
              d.st      = otpcs_pkg::S_CELL;
              d.cellReq = 1'b1;
            end
            default: d.st = otpcs_pkg::S_IDLE;
          endcase
        end
      end
      otpcs_pkg::S_RUN: begin
        if (q.modeSel != q.opMode) begin
          d.st = otpcs_pkg::S_IDLE;
        end else if (q.opMode == otpcs_pkg::MODE_AUTO_READ) begin
          if (q.remaining != 14'h0 && q.count != otpcs_pkg::FIFO_FULL) begin
            d.st      = otpcs_pkg::S_CELL;
            d.cellReq = 1'b1;
          end else if (q.remaining == 14'h0 && (!q.dmaEn || (q.count == 4'h0 && !q.dmaReq))) begin
            d.st                          = otpcs_pkg::S_IDLE;
            irqSet[otpcs_pkg::IRQ_AUTO_DONE] = 1'b1;
          end
        end else begin
          if (q.count != 4'h0 && (q.portSel || q.remaining != 14'h0)) begin
            hwPop       = 1'b1;
            d.st        = otpcs_pkg::S_CELL;
            d.cellReq   = 1'b1;
            d.cellWdata = head;
          end else if (!q.portSel && q.remaining == 14'h0 && !q.dmaReq) begin
            d.st                          = otpcs_pkg::S_IDLE;
            irqSet[otpcs_pkg::IRQ_AUTO_DONE] = 1'b1;
          end
        end
      end
      otpcs_pkg::S_CELL: begin
        if (cellAck) begin
          d.cellReq = 1'b0;
          if (autoOp) begin
            d.st       = otpcs_pkg::S_RUN;
            d.cellAddr = q.cellAddr + 13'h1;
            if (!(q.opMode == otpcs_pkg::MODE_AUTO_PROG && q.portSel)) begin
              d.remaining = q.remaining - otpcs_pkg::ONE14;
            end
          end else begin
            d.st = otpcs_pkg::S_IDLE;
          end
          if (q.opMode == otpcs_pkg::MODE_AUTO_READ) begin
            hwPush   = 1'b1;
            pushData = cellRdata;
          end else if (q.opMode == otpcs_pkg::MODE_AUTO_PROG
                       || q.opMode == otpcs_pkg::MODE_MAN_PROG) begin
            d.progFail = cellFailUpper || cellFailLower;
            d.failU    = cellFailUpper;
            d.failL    = cellFailLower;
            irqSet[otpcs_pkg::IRQ_PROG_FAIL] = cellFailUpper || cellFailLower;
            irqSet[otpcs_pkg::IRQ_MAN_DONE]  = q.opMode == otpcs_pkg::MODE_MAN_PROG;
          end else begin
            d.testFail = cellFailUpper || cellFailLower;
            irqSet[otpcs_pkg::IRQ_TEST_DONE] = 1'b1;
          end
        end
      end
      default: d.st = otpcs_pkg::S_IDLE;
    endcase

    // Bus master moves FIFO words when DMA is on.
    if (q.dmaReq) begin
      if (dmaAck) begin
        d.dmaReq      = 1'b0;
        d.dmaWordAddr = q.dmaWordAddr + 30'h1;
        if (q.dmaWrite) begin
          hwPop = 1'b1;
        end else begin
          hwPush    = 1'b1;
          pushData  = dmaRdata;
          d.dmaLeft = q.dmaLeft - otpcs_pkg::ONE14;
        end
      end
    end else if (q.st != otpcs_pkg::S_IDLE && q.dmaEn) begin
      if (q.opMode == otpcs_pkg::MODE_AUTO_READ && q.count != 4'h0) begin
        d.dmaReq   = 1'b1;
        d.dmaWrite = 1'b1;
        d.dmaWdata = head;
      end else if (q.opMode == otpcs_pkg::MODE_AUTO_PROG && q.count != otpcs_pkg::FIFO_FULL
                   && (q.portSel || q.dmaLeft != 14'h0)) begin
        d.dmaReq   = 1'b1;
        d.dmaWrite = 1'b0;
      end
    end

    // FIFO update; only one pusher and one popper are active per mode.
    if (swPush) begin
      pushData = mw;
    end
    if (swPush || hwPush) begin
      d.mem[q.wrPtr] = pushData;
      d.wrPtr        = q.wrPtr + 3'h1;
    end
    if (swPop || hwPop) begin
      d.rdPtr = q.rdPtr + 3'h1;
    end
    d.count = q.count + {3'h0, swPush || hwPush} - {3'h0, swPop || hwPop};
    if (go && q.st == otpcs_pkg::S_IDLE) begin
      d.rdPtr = '0;
      d.wrPtr = '0;
      d.count = '0;
    end

    // Set wins over a software clear in the same cycle.
    d.irqStat = d.irqStat | irqSet;
  end

  // State register with synchronous reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q    <= '0;
      q.st <= otpcs_pkg::S_IDLE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs.
  assign bvalid    = q.bValid;
  assign bresp     = q.bResp;
  assign rvalid    = q.rValid;
  assign rdata     = q.rData;
  assign rresp     = q.rResp;
  assign irq       = |(q.irqStat & q.irqMask);
  assign cellReq   = q.cellReq;
  assign cellOp    = q.opMode;
  assign cellAddr  = q.cellAddr;
  assign cellWdata = q.cellWdata;
  assign dmaReq    = q.dmaReq;
  assign dmaWrite  = q.dmaWrite;
  assign dmaAddr   = {q.dmaWordAddr, 2'b00};
  assign dmaWdata  = q.dmaWdata;

  // ==========================================================================
  // Checks.
  logic cellDoneNow;
  logic fifoIn;
  logic fifoOut;
  assign cellDoneNow = q.st == otpcs_pkg::S_CELL && cellAck;
  assign fifoIn      = d.wrPtr != q.wrPtr && q.st != otpcs_pkg::S_IDLE;
  assign fifoOut     = d.rdPtr != q.rdPtr && q.st != otpcs_pkg::S_IDLE;

  sequence seqAutoStep;
    cellDoneNow && autoOp;
  endsequence

  sequence seqTestEnd;
    cellDoneNow && q.opMode >= otpcs_pkg::MODE_BLANK_TEST;
  endsequence

  a_fifo_level_up: assert property (@(posedge clk) disable iff (!rst_n)
    fifoIn && !fifoOut |=> statWord[11:8] == $past(statWord[11:8]) + 4'h1)
    else $error("FIFO level did not rise on push");
  a_auto_busy_bit: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == otpcs_pkg::S_RUN |-> !statWord[otpcs_pkg::STAT_ARDY])
    else $error("auto ready high during automatic run");
  a_test_result: assert property (@(posedge clk) disable iff (!rst_n)
    seqTestEnd |=> statWord[3] == $past(cellFailUpper || cellFailLower) && statWord[2])
    else $error("test result or ready wrong after test end");
  a_test_busy: assert property (@(posedge clk) disable iff (!rst_n)
    cellReq && cellOp >= otpcs_pkg::MODE_BLANK_TEST |-> !statWord[otpcs_pkg::STAT_TRDY])
    else $error("test ready high while test runs");
  a_prog_fail_bank: assert property (@(posedge clk) disable iff (!rst_n)
    cellDoneNow && q.opMode == otpcs_pkg::MODE_MAN_PROG
    |=> statWord[1] == $past(cellFailUpper || cellFailLower) && statWord[13] == $past(cellFailUpper)
        && statWord[0])
    else $error("program fail flag or bank mismatch");
  a_prog_idle_bit: assert property (@(posedge clk) disable iff (!rst_n)
    cellReq && (cellOp == otpcs_pkg::MODE_AUTO_PROG || cellOp == otpcs_pkg::MODE_MAN_PROG)
    |-> !statWord[otpcs_pkg::STAT_PRDY])
    else $error("program idle high during program step");
  a_dma_addr_step: assert property (@(posedge clk) disable iff (!rst_n)
    dmaReq && dmaAck |=> dmaAddr == $past(dmaAddr) + 32'h4 && dmaAddr[1:0] == 2'b00)
    else $error("bus master address did not step one word");
  a_cell_addr_step: assert property (@(posedge clk) disable iff (!rst_n)
    seqAutoStep |=> cellAddr == $past(cellAddr) + 13'h1)
    else $error("cell address did not advance");
  a_count_stable: assert property (@(posedge clk) disable iff (!rst_n)
    !(wrEn && awaddr == otpcs_pkg::ADDR_COUNT) |=> $stable(q.wordCount))
    else $error("word count changed without a write");
  a_remain_step: assert property (@(posedge clk) disable iff (!rst_n)
    seqAutoStep ##0 !q.portSel |=> statWord[28:16] == $past(statWord[28:16]) - 13'h1)
    else $error("remaining words did not count down");
  a_port_capture: assert property (@(posedge clk) disable iff (!rst_n)
    rdEn && araddr == otpcs_pkg::ADDR_PORT && q.modeSel == otpcs_pkg::MODE_AUTO_READ && !q.dmaEn
    && q.count != 4'h0 |=> q.lastRead == $past(head) ##1 q.lastRead == $past(head, 2))
    else $error("last popped word not captured");
endmodule : otpcs_ctrl
`default_nettype wire

// ===== verification/otpcs_cell_model.sv
// Behavioural OTP macrocell and system bus memory that answer the controller's requests.
`timescale 1ns/1ps
`default_nettype none
module otpcs_cell_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        slow,
  input  wire logic [1:0]  fail,
  input  wire logic        cellReq,
  input  wire logic [12:0] cellAddr,
  output logic             cellAck,
  output logic [31:0]      cellRdata,
  output logic             cellFailUpper,
  output logic             cellFailLower
);
  logic [3:0] waitQ;
  // Counts the cycles of a pending request and restarts after each answer.
  always_ff @(posedge clk) begin
    if (!rst_n || !cellReq || cellAck) begin
      waitQ <= 4'h0;
    end else begin
      waitQ <= waitQ + 4'h1;
    end
  end
  // One-cycle answer after 1 or 6 cycles; outside it the data shows the inverse pattern.
  assign cellAck       = cellReq && (waitQ == (slow ? 4'h6 : 4'h1));
  assign cellRdata     = cellAck ? {19'h2a5a5, cellAddr} : ~{19'h2a5a5, cellAddr};
  assign cellFailUpper = cellAck & fail[1];
  assign cellFailLower = cellAck & fail[0];
endmodule : otpcs_cell_model

module otpcs_bus_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        dmaReq,
  input  wire logic [31:0] dmaAddr,
  output logic             dmaAck,
  output logic [31:0]      dmaRdata
);
  // Answers each bus-master request once, one cycle after it is seen.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dmaAck <= 1'b0;
    end else begin
      dmaAck <= dmaReq && !dmaAck;
    end
  end
  // Memory word is the inverted address; outside the answer the bus shows the plain address.
  assign dmaRdata = dmaAck ? ~dmaAddr : dmaAddr;
endmodule : otpcs_bus_model
`default_nettype wire

// ===== verification/otpcs_ctrl_tb_top.sv
// Self-checking bench for the OTP status, address, count and FIFO port registers.
`timescale 1ns/1ps
`default_nettype none
module otpcs_ctrl_tb_top;
  logic        clk, rst_n, awvalid, wvalid, bvalid, arvalid, rvalid, slow;
  logic        awready, wready, arready, irq, cellReq, cellAck, cellFailUpper, cellFailLower;
  logic [1:0]  bresp, rresp, resp, fail;
  logic [12:0] cellAddr;
  logic [31:0] awaddr, wdata, araddr, rdata, cellRdata, s;
  logic        dmaReq, dmaAck;
  logic [31:0] cellWdata, dmaAddr, dmaWdata, dmaRdata, seenW, seenD;
  int          err_count, n_tests;
  // Design under test; strobes and response readiness are tied.
  otpcs_ctrl u_otpcs_ctrl (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready(1'b1), .irq, .cellReq, .cellOp(), .cellAddr, .cellWdata,
    .cellAck, .cellRdata, .cellFailUpper, .cellFailLower, .dmaReq, .dmaWrite(),
    .dmaAddr, .dmaWdata, .dmaAck, .dmaRdata);
  otpcs_cell_model u_otpcs_cell_model (.clk, .rst_n, .slow, .fail, .cellReq, .cellAddr,
    .cellAck, .cellRdata, .cellFailUpper, .cellFailLower);
  otpcs_bus_model u_otpcs_bus_model (.clk, .rst_n, .dmaReq, .dmaAddr, .dmaAck, .dmaRdata);
  // Records the word handed over at each macrocell and bus-master completion.
  always @(posedge clk) begin
    if (cellAck) begin
      seenW <= cellWdata;
    end
    if (dmaReq && dmaAck) begin
      seenD <= dmaWdata;
    end
  end
  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
  endtask : rd
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    rd(a, s);
    chk(s, e);
  endtask : rc
  task automatic poll(input int b);
    do rd(otpcs_pkg::ADDR_STAT, s); while (s[b] !== 1'b1);
  endtask : poll
  task automatic irqChk(input logic e);
    @(posedge clk);
    @(negedge clk);
    chk(32'(irq), 32'(e));
    @(posedge clk);
  endtask : irqChk
  task automatic t_reset();
    rc(otpcs_pkg::ADDR_STAT, 32'h0000_0015);
    for (int i = 3; i < 8; i++) begin
      rc(32'h4000_8000 + 32'(i * 4), 32'h0);
    end
    $display("reset values done");
  endtask : t_reset
  task automatic t_regs();
    wr(otpcs_pkg::ADDR_DMA, 32'h1234_5677);
    rc(otpcs_pkg::ADDR_DMA, 32'h1234_5674);
    wr(otpcs_pkg::ADDR_CELL, 32'hffff_ffff);
    rc(otpcs_pkg::ADDR_CELL, 32'h0000_1fff);
    wr(otpcs_pkg::ADDR_COUNT, 32'hffff_ffff);
    rc(otpcs_pkg::ADDR_COUNT, 32'h0000_1fff);
    wr(otpcs_pkg::ADDR_LAST, 32'h5);
    rc(otpcs_pkg::ADDR_LAST, 32'h0);
    wr(32'h4000_8030, 32'h1);
    chk(32'(resp), 32'(otpcs_pkg::RESP_SLVERR));
    rc(32'h4000_8030, 32'h0);
    $display("register access done");
  endtask : t_regs
  task automatic t_auto_read_mode();
    wr(otpcs_pkg::ADDR_CELL, 32'h5);
    wr(otpcs_pkg::ADDR_COUNT, 32'h1);
    wr(otpcs_pkg::ADDR_IRQ_MASK, 32'h1);
    wr(otpcs_pkg::ADDR_CTRL, 32'h101);
    rd(otpcs_pkg::ADDR_STAT, s);
    chk(32'({s[28:16], s[4]}), 32'h4);
    poll(4);
    chk(s & 32'h1fff_0f10, 32'h0000_0210);
    rc(otpcs_pkg::ADDR_CELL, 32'h7);
    rc(otpcs_pkg::ADDR_COUNT, 32'h1);
    for (int i = 0; i < 2; i++) begin
      rd(otpcs_pkg::ADDR_STAT, s);
      chk(32'(s[11:8]), 32'(2 - i));
      rc(otpcs_pkg::ADDR_PORT, {19'h2a5a5, 13'(5 + i)});
    end
    rc(otpcs_pkg::ADDR_LAST, {19'h2a5a5, 13'h6});
    irqChk(1'b1);
    wr(otpcs_pkg::ADDR_IRQ_MASK, 32'h0);
    irqChk(1'b0);
    wr(otpcs_pkg::ADDR_IRQ_MASK, 32'h1);
    irqChk(1'b1);
    wr(otpcs_pkg::ADDR_IRQ_STAT, 32'h1);
    irqChk(1'b0);
    $display("automatic read done");
  endtask : t_auto_read_mode
  task automatic t_modes();
    fail <= 2'b10;
    wr(otpcs_pkg::ADDR_PORT, 32'ha5);
    wr(otpcs_pkg::ADDR_CTRL, 32'h103);
    poll(0);
    chk(s & 32'h0000_3003, 32'h0000_2003);
    slow <= 1'b0;
    fail <= 2'b00;
    for (int m = 4; m < 7; m++) begin
      wr(otpcs_pkg::ADDR_CTRL, 32'h100 | 32'(m));
      poll(2);
      chk(s & 32'h0000_000c, 32'h4);
    end
    $display("manual program and test modes done");
  endtask : t_modes
  task automatic t_auto_program_mode();
    wr(otpcs_pkg::ADDR_CELL, 32'h20);
    wr(otpcs_pkg::ADDR_COUNT, 32'h1);
    wr(otpcs_pkg::ADDR_CTRL, 32'h102);
    for (int i = 0; i < 2; i++) begin
      wr(otpcs_pkg::ADDR_PORT, 32'hc0de_0000 + 32'(i));
    end
    poll(4);
    chk(seenW, 32'hc0de_0001);
    chk(s & 32'h1fff_0f00, 32'h0);
    rc(otpcs_pkg::ADDR_CELL, 32'h22);
    wr(otpcs_pkg::ADDR_CTRL, 32'h122);
    wr(otpcs_pkg::ADDR_PORT, 32'h77);
    wr(otpcs_pkg::ADDR_CTRL, 32'h0);
    poll(4);
    chk(seenW, 32'h77);
    rc(otpcs_pkg::ADDR_COUNT, 32'h1);
    $display("automatic program done");
  endtask : t_auto_program_mode
  task automatic t_dma();
    wr(otpcs_pkg::ADDR_DMA, 32'h100);
    wr(otpcs_pkg::ADDR_CELL, 32'h10);
    wr(otpcs_pkg::ADDR_COUNT, 32'h0);
    wr(otpcs_pkg::ADDR_CTRL, 32'h111);
    poll(4);
    chk(seenD, {19'h2a5a5, 13'h10});
    rc(otpcs_pkg::ADDR_DMA, 32'h104);
    wr(otpcs_pkg::ADDR_CTRL, 32'h112);
    poll(4);
    chk(seenW, ~32'h104);
    rc(otpcs_pkg::ADDR_DMA, 32'h108);
    $display("bus master transfers done");
  endtask : t_dma
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // Main sequence: reset for five cycles, then the scenarios.
  initial begin
    {rst_n, awvalid, wvalid, arvalid, fail, awaddr, wdata, araddr} = '0;
    slow = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_auto_read_mode();
    t_modes();
    t_auto_program_mode();
    t_dma();
    end_sim();
  end
endmodule : otpcs_ctrl_tb_top
`default_nettype wire
